// [bench/fsg_serializer_model.sv]
// remote serializer stand-in: counts pulse starts seen on slot 0 of every port
// assumes slot outputs are registered on hclk
`timescale 1ns/100ps
module fsg_serializer_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // back-channel slots from the hub
    input wire logic [15:0] slot_in,
    // per-port count of pulse starts
    output logic [3:0][7:0] rise_cnt
);
    logic [15:0] slot_reg;
    // equal counts across ports show the ports stay in step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slot_reg <= 16'h0000;
            rise_cnt <= '0;
        end else begin
            slot_reg <= slot_in;
            for (int p = 0; p < 4; p++) begin
                if (slot_in[4*p] && !slot_reg[4*p]) begin
                    rise_cnt[p] <= rise_cnt[p] + 8'h01;
                end
            end
        end
    end
endmodule : fsg_serializer_model

// [bench/tb_frame_sync_generator.sv]
// testbench for the frame pulse block: ahb-lite master tasks and timing checks
// assumes one slave whose hreadyout is fed back as hready
`timescale 1ns/100ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, act, exp); end end
module tb_frame_sync_generator;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, frame_pulse_out;
    logic [31:0] hrdata;
    logic [7:0] local_pin_in = 8'h00;
    logic [15:0] backchan_slot_out;
    logic [3:0][7:0] rise_cnt;
    int num_errors = 0;
    int comparisons = 0;
    int cyc = 0;
    int hi, lo, t0;

    fsg_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .local_pin_in(local_pin_in), .backchan_slot_out(backchan_slot_out),
        .frame_pulse_out(frame_pulse_out));
    fsg_serializer_model i_ser (.hclk(hclk), .hresetn(hresetn),
        .slot_in(backchan_slot_out), .rise_cnt(rise_cnt));

    // 250 MHz clock
    always #2 hclk = ~hclk;

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // cycle count doubles as timestamp; ceiling covers all phases measured
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    // single word transfer, waits on hready for both phases
    task automatic ahb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] rd;
        ahb(1'b1, idx, d, rd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, idx, 8'h00, rd);
        `CHK(rd, exp)
        `CHK(hresp, 1'b0)
    endtask : rd_chk

    task automatic wait_lvl(input logic v);
        do @(posedge hclk); while (frame_pulse_out !== v);
    endtask : wait_lvl

    // one full high phase then the following low phase, in cycles
    task automatic measure();
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        t0 = cyc;
        wait_lvl(1'b0);
        hi = cyc - t0;
        t0 = cyc;
        wait_lvl(1'b1);
        lo = cyc - t0;
    endtask : measure

    task automatic t_regs();
        rd_chk(fsg_pkg::IDX_GEN_CTL, 32'h0);
        rd_chk(fsg_pkg::IDX_LOW_LO, 32'h0);
        wr(fsg_pkg::IDX_HIGH_HI, 8'h0a);
        wr(fsg_pkg::IDX_HIGH_LO, 8'hd7);
        rd_chk(fsg_pkg::IDX_HIGH_HI, 32'h0a);
        rd_chk(fsg_pkg::IDX_HIGH_LO, 32'hd7);
        rd_chk(fsg_pkg::IDX_NONE, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_external();
        for (int p = 0; p < 4; p++) begin
            wr(fsg_pkg::IDX_PIN_CTL_BASE + 8'(2 * p), 8'haa);
        end
        wr(fsg_pkg::IDX_PIN_CTL_BASE + 8'h01, 8'ha5);
        wr(fsg_pkg::IDX_GEN_CTL, 8'h90);
        @(posedge hclk);
        local_pin_in <= 8'h02;
        repeat (5) @(posedge hclk);
        `CHK(frame_pulse_out, 1'b1)
        `CHK(backchan_slot_out, 16'h333b)
        @(posedge hclk);
        local_pin_in <= 8'hfd;
        repeat (5) @(posedge hclk);
        `CHK(backchan_slot_out, 16'h0000)
        $display("test external done");
    endtask : t_external

    task automatic t_internal();
        wr(fsg_pkg::IDX_RATE_BASE, 8'h06);
        wr(fsg_pkg::IDX_HIGH_HI, 8'h00);
        wr(fsg_pkg::IDX_HIGH_LO, 8'h02);
        wr(fsg_pkg::IDX_LOW_LO, 8'h03);
        wr(fsg_pkg::IDX_GEN_CTL, 8'h01);
        measure();
        `CHK(hi, 300)
        `CHK(lo, 450)
        measure();
        `CHK(hi + lo, 750)
        `CHK(rise_cnt[0], rise_cnt[3])
        t0 = cyc;
        wr(fsg_pkg::IDX_HIGH_LO, 8'h04);
        wait_lvl(1'b0);
        `CHK(cyc - t0, 300)
        measure();
        `CHK(hi, 600)
        $display("test internal done");
    endtask : t_internal

    task automatic t_duty_src();
        wr(fsg_pkg::IDX_GEN_CTL, 8'h00);
        repeat (2) @(posedge hclk);
        `CHK(frame_pulse_out, 1'b0)
        wr(fsg_pkg::IDX_RATE_BASE, 8'h00);
        wr(fsg_pkg::IDX_RATE_BASE + 8'h01, 8'h06);
        wr(fsg_pkg::IDX_GEN_CTL, 8'h17);
        repeat (2) @(posedge hclk);
        `CHK(frame_pulse_out, 1'b1)
        rd_chk(fsg_pkg::IDX_STATUS, 32'h3);
        measure();
        `CHK(hi, 600)
        `CHK(lo, 600)
        wr(fsg_pkg::IDX_GEN_CTL, 8'h00);
        // source 4 has no tick: the engine enters low and must stay frozen there
        wr(fsg_pkg::IDX_GEN_CTL, 8'h41);
        repeat (400) @(posedge hclk);
        `CHK(frame_pulse_out, 1'b0)
        rd_chk(fsg_pkg::IDX_STATUS, 32'h4);
        wr(fsg_pkg::IDX_GEN_CTL, 8'h00);
        $display("test duty and source done");
    endtask : t_duty_src

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_external();
        t_internal();
        t_duty_src();
        give_verdict();
    end
endmodule : tb_frame_sync_generator

// [hw/fsg_pkg.sv]
// frame pulse generator: shared constants, register map and state types
// assumes a single 250 MHz bus clock shared by every module of the block
package fsg_pkg;
    // clock and back-channel timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int BC_FRAME_BITS = 30;
    localparam int BC_BIT_SLOW_NS = 400;
    localparam int BC_BIT_FAST_NS = 20;
    localparam int TICK_W = 12;
    localparam logic [TICK_W-1:0] TICK_SLOW_CYC =
        TICK_W'(BC_FRAME_BITS * BC_BIT_SLOW_NS / CLK_PERIOD_NS);
    localparam logic [TICK_W-1:0] TICK_FAST_CYC =
        TICK_W'(BC_FRAME_BITS * BC_BIT_FAST_NS / CLK_PERIOD_NS);
    localparam logic [2:0] RATE_FAST = 3'h6;
    localparam logic [2:0] RATE_RST = 3'h0;
    // geometry
    localparam int NUM_PORTS = 4;
    localparam int NUM_SLOTS = 4;
    localparam int NUM_PINS = 8;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_GEN_CTL = 8'h18;
    localparam logic [7:0] IDX_HIGH_HI = 8'h19;
    localparam logic [7:0] IDX_HIGH_LO = 8'h1a;
    localparam logic [7:0] IDX_LOW_HI = 8'h1b;
    localparam logic [7:0] IDX_LOW_LO = 8'h1c;
    localparam logic [7:0] IDX_PIN_CTL_BASE = 8'h20;
    localparam logic [7:0] IDX_RATE_BASE = 8'h28;
    localparam logic [7:0] IDX_STATUS = 8'h2c;
    localparam logic [7:0] IDX_NONE = 8'hff;
    // control field positions
    localparam int CTL_ON_BIT = 0;
    localparam int CTL_DUTY_BIT = 1;
    localparam int CTL_START_BIT = 2;
    localparam int CTL_SEL_LSB = 4;
    // reset values and codes
    localparam logic [7:0] GEN_CTL_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [7:0] PIN_CTL_RST = 8'h00;
    localparam logic [3:0] SLOT_SRC_FRAME = 4'ha;
    localparam logic [3:0] SEL_EXT_MIN = 4'h8;

    typedef enum logic [1:0] {
        GEN_IDLE = 2'b00,
        GEN_HIGH = 2'b01,
        GEN_LOW = 2'b10
    } fsg_gen_state_t;

    typedef enum logic [1:0] {
        DPH_NONE = 2'b00,
        DPH_WRITE = 2'b01,
        DPH_RD_WAIT = 2'b10,
        DPH_RD_OK = 2'b11
    } fsg_dphase_t;
endpackage : fsg_pkg

// [hw/fsg_tick_gen.sv]
// per-port back-channel frame period tick source
// assumes rate selections are stable register outputs on the same clock
`timescale 1ns/100ps
module fsg_tick_gen (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // rate select in, ticks out
    fsg_tick_if.gen tick_bus
);
    genvar p;
    generate
        for (p = 0; p < fsg_pkg::NUM_PORTS; p++) begin : g_port
            logic [fsg_pkg::TICK_W-1:0] cnt_reg;
            logic [fsg_pkg::TICK_W-1:0] cnt_next;
            logic [fsg_pkg::TICK_W-1:0] period;
            logic tick_reg;
            logic tick_next;
            // one tick per back-channel frame; a lowered period wraps at once
            always_comb begin
                period = (tick_bus.rate_sel[p] == fsg_pkg::RATE_FAST) ?
                    fsg_pkg::TICK_FAST_CYC : fsg_pkg::TICK_SLOW_CYC;
                tick_next = (cnt_reg >= period - 12'h001);
                cnt_next = tick_next ? 12'h000 : cnt_reg + 12'h001;
            end
            // all ports leave reset together, so their frames start aligned
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    cnt_reg <= 12'h000;
                    tick_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_next;
                    tick_reg <= tick_next;
                end
            end
            assign tick_bus.tick[p] = tick_reg;

            property p_tick_gap;
                @(posedge hclk) disable iff (!hresetn)
                tick_reg |=> !tick_reg [*8];
            endproperty
            a_tick_gap: assert property (p_tick_gap)
                else $error("tick repeats faster than a back-channel frame");
        end
    endgenerate
endmodule : fsg_tick_gen

// [hw/fsg_tick_if.sv]
// carrier between the register/generator top and the per-port tick source
// assumes both ends run on the same bus clock
`timescale 1ns/100ps
interface fsg_tick_if;
    logic [fsg_pkg::NUM_PORTS-1:0][2:0] rate_sel;
    logic [fsg_pkg::NUM_PORTS-1:0] tick;
    modport gen (input rate_sel, output tick);
    modport ctl (output rate_sel, input tick);
endinterface : fsg_tick_if

// [hw/fsg_top.sv]
// frame pulse generator top: ahb-lite registers, pin relay, pulse engine
// assumes one ahb-lite master and local pins asynchronous to hclk
// Notes on behaviour
// - any back-channel slot of any port can carry the frame pulse.
// - external mode relays a local pin to selected back-channel slots.
// - source select 0x8..0xf picks pins 0..7 while generator stays off.
// - a slot carries the pulse only if its control selects the pulse.
// - all ports' slots update on the same edge from one pulse.
// - setting generator on starts internal pulse generation.
// - source select chooses which port tick times the generator.
// - duty style picks fixed half/half or separate high and low counts.
// - tick equals back-channel frame period; slow rate gives 30 x 400 ns.
// - once on, the pulse repeats without further triggering.
// - low phase lasts low count ticks (high count in half/half duty), high phase high count ticks.
// - start level bit sets the first phase; zero starts low.
// - source select zero uses port 0 frame period as tick.
// - counts are 16 bits, upper and lower byte, high at 0x19/0x1a.
`timescale 1ns/100ps
module fsg_top (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // local general-purpose pins
    input wire logic [fsg_pkg::NUM_PINS-1:0] local_pin_in,
    // back-channel slots, port-major
    output logic [fsg_pkg::NUM_PORTS*fsg_pkg::NUM_SLOTS-1:0] backchan_slot_out,
    output logic frame_pulse_out
);
    localparam int NSLOT = fsg_pkg::NUM_PORTS * fsg_pkg::NUM_SLOTS;

    fsg_tick_if tick_bus ();

    fsg_tick_gen u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick_bus(tick_bus)
    );

    // registers
    logic [7:0] pulse_gen_control_reg, pulse_gen_control_next;
    logic [15:0] pulse_high_count_reg, pulse_high_count_next;
    logic [15:0] pulse_low_count_reg, pulse_low_count_next;
    logic [7:0] pin_ctl_reg [0:2*fsg_pkg::NUM_PORTS-1];
    logic [7:0] pin_ctl_next [0:2*fsg_pkg::NUM_PORTS-1];
    logic [2:0] rate_reg [0:fsg_pkg::NUM_PORTS-1];
    logic [2:0] rate_next [0:fsg_pkg::NUM_PORTS-1];
    // bus phase
    fsg_pkg::fsg_dphase_t dph_reg, dph_next;
    logic [7:0] idx_reg, idx_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic [31:0] rd_val;
    logic addr_take;
    // generator
    fsg_pkg::fsg_gen_state_t state_reg, state_next;
    logic [15:0] left_reg, left_next;
    logic pulse_reg, pulse_next;
    logic [NSLOT-1:0] slot_reg, slot_next;
    logic [NSLOT-1:0] fp_mask;
    logic [fsg_pkg::NUM_PINS-1:0] pin_meta_reg, pin_sync_reg;
    logic [3:0] src_sel;
    logic gen_on, duty_half, start_high, gen_tick, ext_mode;
    logic [15:0] high_len, low_len;

    assign src_sel = pulse_gen_control_reg[fsg_pkg::CTL_SEL_LSB +: 4];
    assign gen_on = pulse_gen_control_reg[fsg_pkg::CTL_ON_BIT];
    assign duty_half = pulse_gen_control_reg[fsg_pkg::CTL_DUTY_BIT];
    assign start_high = pulse_gen_control_reg[fsg_pkg::CTL_START_BIT];
    assign ext_mode = !gen_on && (src_sel >= fsg_pkg::SEL_EXT_MIN);

    // tick source: port ticks for 0..3, none otherwise so the engine stalls
    assign gen_tick = (src_sel < 4'(fsg_pkg::NUM_PORTS)) ?
        tick_bus.tick[src_sel[1:0]] : 1'b0;
    // zero counts would wrap and run a phase for 65536 ticks, so they act as one tick
    assign high_len = (pulse_high_count_reg == 16'h0000) ? 16'h0001 : pulse_high_count_reg;
    assign low_len = duty_half ? high_len :
        ((pulse_low_count_reg == 16'h0000) ? 16'h0001 : pulse_low_count_reg);

    // ahb-lite data phase: writes need no wait, reads take one wait state
    // so the read mux always sees a write from the preceding transfer
    assign addr_take = hsel && htrans[1] && hready;
    always_comb begin
        dph_next = dph_reg;
        idx_next = idx_reg;
        hrdata_next = hrdata_reg;
        if (dph_reg == fsg_pkg::DPH_RD_WAIT) begin
            hrdata_next = rd_val;
            dph_next = fsg_pkg::DPH_RD_OK;
        end else if (addr_take) begin
            dph_next = hwrite ? fsg_pkg::DPH_WRITE : fsg_pkg::DPH_RD_WAIT;
            idx_next = (haddr[31:10] == 22'h000000 && haddr[1:0] == 2'h0) ?
                haddr[9:2] : fsg_pkg::IDX_NONE;
        end else begin
            dph_next = fsg_pkg::DPH_NONE;
        end
    end

    // read mux; unmapped and reserved bits read as zero
    always_comb begin
        rd_val = 32'h00000000;
        case (idx_reg)
            fsg_pkg::IDX_GEN_CTL: rd_val[7:0] = pulse_gen_control_reg;
            fsg_pkg::IDX_HIGH_HI: rd_val[7:0] = pulse_high_count_reg[15:8];
            fsg_pkg::IDX_HIGH_LO: rd_val[7:0] = pulse_high_count_reg[7:0];
            fsg_pkg::IDX_LOW_HI: rd_val[7:0] = pulse_low_count_reg[15:8];
            fsg_pkg::IDX_LOW_LO: rd_val[7:0] = pulse_low_count_reg[7:0];
            fsg_pkg::IDX_STATUS: rd_val[2:0] = {state_reg, pulse_reg};
            default: begin
                for (int i = 0; i < 2 * fsg_pkg::NUM_PORTS; i++) begin
                    if (idx_reg == fsg_pkg::IDX_PIN_CTL_BASE + 8'(i)) begin
                        rd_val[7:0] = pin_ctl_reg[i];
                    end
                end
                for (int i = 0; i < fsg_pkg::NUM_PORTS; i++) begin
                    if (idx_reg == fsg_pkg::IDX_RATE_BASE + 8'(i)) begin
                        rd_val[2:0] = rate_reg[i];
                    end
                end
            end
        endcase
    end

    // register writes in the data phase; low byte lane only
    always_comb begin
        pulse_gen_control_next = pulse_gen_control_reg;
        pulse_high_count_next = pulse_high_count_reg;
        pulse_low_count_next = pulse_low_count_reg;
        pin_ctl_next = pin_ctl_reg;
        rate_next = rate_reg;
        if (dph_reg == fsg_pkg::DPH_WRITE) begin
            case (idx_reg)
                fsg_pkg::IDX_GEN_CTL: pulse_gen_control_next = hwdata[7:0];
                fsg_pkg::IDX_HIGH_HI: pulse_high_count_next[15:8] = hwdata[7:0];
                fsg_pkg::IDX_HIGH_LO: pulse_high_count_next[7:0] = hwdata[7:0];
                fsg_pkg::IDX_LOW_HI: pulse_low_count_next[15:8] = hwdata[7:0];
                fsg_pkg::IDX_LOW_LO: pulse_low_count_next[7:0] = hwdata[7:0];
                default: begin
                    for (int i = 0; i < 2 * fsg_pkg::NUM_PORTS; i++) begin
                        if (idx_reg == fsg_pkg::IDX_PIN_CTL_BASE + 8'(i)) begin
                            pin_ctl_next[i] = hwdata[7:0];
                        end
                    end
                    for (int i = 0; i < fsg_pkg::NUM_PORTS; i++) begin
                        if (idx_reg == fsg_pkg::IDX_RATE_BASE + 8'(i)) begin
                            rate_next[i] = hwdata[2:0];
                        end
                    end
                end
            endcase
        end
    end

    // pulse engine; lengths are loaded only on phase entry
    always_comb begin
        state_next = state_reg;
        left_next = left_reg;
        case (state_reg)
            fsg_pkg::GEN_IDLE: begin
                if (gen_on) begin
                    state_next = start_high ? fsg_pkg::GEN_HIGH : fsg_pkg::GEN_LOW;
                    left_next = start_high ? high_len : low_len;
                end
            end
            fsg_pkg::GEN_HIGH: begin
                if (!gen_on) begin
                    state_next = fsg_pkg::GEN_IDLE;
                end else if (gen_tick) begin
                    if (left_reg == 16'h0001) begin
                        state_next = fsg_pkg::GEN_LOW;
                        left_next = low_len;
                    end else begin
                        left_next = left_reg - 16'h0001;
                    end
                end
            end
            fsg_pkg::GEN_LOW: begin
                if (!gen_on) begin
                    state_next = fsg_pkg::GEN_IDLE;
                end else if (gen_tick) begin
                    if (left_reg == 16'h0001) begin
                        state_next = fsg_pkg::GEN_HIGH;
                        left_next = high_len;
                    end else begin
                        left_next = left_reg - 16'h0001;
                    end
                end
            end
            default: state_next = fsg_pkg::GEN_IDLE;
        endcase
    end

    // pulse source: engine, synchronised pin, or quiet low
    always_comb begin
        if (gen_on) begin
            pulse_next = (state_next == fsg_pkg::GEN_HIGH);
        end else if (ext_mode) begin
            pulse_next = pin_sync_reg[src_sel[2:0]];
        end else begin
            pulse_next = 1'b0;
        end
    end

    // slot routing: each slot owns one nibble of its port's control pair
    genvar s;
    generate
        for (s = 0; s < NSLOT; s++) begin : g_slot
            localparam int PORT = s / fsg_pkg::NUM_SLOTS;
            localparam int SUB = s % fsg_pkg::NUM_SLOTS;
            assign fp_mask[s] = (pin_ctl_reg[2*PORT + SUB/2][4*(SUB%2) +: 4]
                == fsg_pkg::SLOT_SRC_FRAME);
            assign slot_next[s] = fp_mask[s] && pulse_reg;
        end
    endgenerate

    // every register lands on one edge, keeping all ports in step
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_reg <= fsg_pkg::DPH_NONE;
            idx_reg <= fsg_pkg::IDX_NONE;
            hrdata_reg <= 32'h00000000;
            pulse_gen_control_reg <= fsg_pkg::GEN_CTL_RST;
            pulse_high_count_reg <= fsg_pkg::COUNT_RST;
            pulse_low_count_reg <= fsg_pkg::COUNT_RST;
            for (int i = 0; i < 2 * fsg_pkg::NUM_PORTS; i++) begin
                pin_ctl_reg[i] <= fsg_pkg::PIN_CTL_RST;
            end
            for (int i = 0; i < fsg_pkg::NUM_PORTS; i++) begin
                rate_reg[i] <= fsg_pkg::RATE_RST;
            end
            state_reg <= fsg_pkg::GEN_IDLE;
            left_reg <= 16'h0000;
            pulse_reg <= 1'b0;
            slot_reg <= '0;
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else begin
            dph_reg <= dph_next;
            idx_reg <= idx_next;
            hrdata_reg <= hrdata_next;
            pulse_gen_control_reg <= pulse_gen_control_next;
            pulse_high_count_reg <= pulse_high_count_next;
            pulse_low_count_reg <= pulse_low_count_next;
            pin_ctl_reg <= pin_ctl_next;
            rate_reg <= rate_next;
            state_reg <= state_next;
            left_reg <= left_next;
            pulse_reg <= pulse_next;
            slot_reg <= slot_next;
            pin_meta_reg <= local_pin_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    generate
        for (s = 0; s < fsg_pkg::NUM_PORTS; s++) begin : g_rate
            assign tick_bus.rate_sel[s] = rate_reg[s];
        end
    endgenerate

    assign hreadyout = (dph_reg != fsg_pkg::DPH_RD_WAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign backchan_slot_out = slot_reg;
    assign frame_pulse_out = pulse_reg;

    // checks
    property p_ext_relay;
        @(posedge hclk) disable iff (!hresetn)
        ext_mode |=> pulse_reg == $past(pin_sync_reg[src_sel[2:0]]);
    endproperty
    a_ext_relay: assert property (p_ext_relay)
        else $error("external pin not relayed to frame pulse");
    property p_slot_gate;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> (slot_reg & ~$past(fp_mask)) == '0;
    endproperty
    a_slot_gate: assert property (p_slot_gate)
        else $error("slot carries pulse without selecting it");
    property p_slot_sync;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> slot_reg == ($past(fp_mask) & {NSLOT{$past(pulse_reg)}});
    endproperty
    a_slot_sync: assert property (p_slot_sync)
        else $error("selected slots disagree with the pulse");
    property p_start_level;
        @(posedge hclk) disable iff (!hresetn)
        (state_reg == fsg_pkg::GEN_IDLE && gen_on) |=>
            (state_reg == (start_high ? fsg_pkg::GEN_HIGH : fsg_pkg::GEN_LOW));
    endproperty
    a_start_level: assert property (p_start_level)
        else $error("generator started at the wrong level");
    property p_off_idle;
        @(posedge hclk) disable iff (!hresetn)
        !gen_on |=> state_reg == fsg_pkg::GEN_IDLE;
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("generator running while off");
    property p_phase_end;
        @(posedge hclk) disable iff (!hresetn)
        (gen_on && gen_tick && left_reg == 16'h0001 && state_reg == fsg_pkg::GEN_HIGH)
            |=> state_reg == fsg_pkg::GEN_LOW && left_reg == $past(low_len);
    endproperty
    a_phase_end: assert property (p_phase_end)
        else $error("high phase did not end into low phase");
    property p_tick_port0;
        @(posedge hclk) disable iff (!hresetn)
        src_sel == 4'h0 |-> gen_tick == tick_bus.tick[0];
    endproperty
    a_tick_port0: assert property (p_tick_port0)
        else $error("source zero not timed by port 0");
    property p_hold_count;
        @(posedge hclk) disable iff (!hresetn)
        (gen_on && !gen_tick && state_reg != fsg_pkg::GEN_IDLE) |=> $stable(left_reg);
    endproperty
    a_hold_count: assert property (p_hold_count)
        else $error("phase length changed between ticks");
    property p_pulse_level;
        @(posedge hclk) disable iff (!hresetn)
        $past(gen_on) |-> pulse_reg == (state_reg == fsg_pkg::GEN_HIGH);
    endproperty
    a_pulse_level: assert property (p_pulse_level)
        else $error("pulse level disagrees with phase");
    c_high_to_low: cover property (@(posedge hclk) disable iff (!hresetn)
        state_reg == fsg_pkg::GEN_HIGH ##1 state_reg == fsg_pkg::GEN_LOW);
    c_ext_mode: cover property (@(posedge hclk) disable iff (!hresetn)
        ext_mode && pulse_reg && slot_reg != '0);
    c_read: cover property (@(posedge hclk) disable iff (!hresetn)
        dph_reg == fsg_pkg::DPH_RD_WAIT ##1 dph_reg == fsg_pkg::DPH_RD_OK);
endmodule : fsg_top
